// ===== hw/pshd_top.sv
/*
 * Programming pad state hold: per-pad scan cells that fix every pad
 * during device programming, loaded over APB.
 * Assumes pclk at 250 MHz, presetn async active low, and that the
 * programming controller loads cells before requesting programming mode.
 * Registers: CTRL 0x000 bit 0 requests programming mode; STAT 0x004 shows
 * the one-hot phase; PRESET 0x008 loads one preset into every pad; SEL 0x00C
 * picks a pad; CELL 0x010 reads or writes that pad's {last, out, oe, in} word.
 * Cell and preset writes are ignored while programming is in force, and any
 * other address answers with pslverr. A select past the last pad reads zero
 * and loads nothing.
 */
// Decided for this implementation: the APB register port and the placing of the registers.
// Overview of operation
// - Output-enable cell 0 tri-states the pad
// - Drive-low preset: oe 1, out 0
// - Drive-high preset: oe 1, out 1
// - Hold-last samples driven value, holds it
// - Three independently loadable cells per pad; here a pad's cells load together as one word
// - Don't-care cells never change pad condition
// - All ones: drive high, input cell 1
`timescale 1ns/1ps
module pshd_top
    import pshd_pkg::*;
#(
    parameter int NPADS = 16              // Number of pads held
)(
    input  wire logic             pclk,      // APB clock
    input  wire logic             presetn,   // Async reset, active low
    input  wire logic             psel,      // APB select
    input  wire logic             penable,   // APB enable
    input  wire logic             pwrite,    // APB direction
    input  wire logic [11:0]      paddr,     // APB byte address
    input  wire logic [31:0]      pwdata,    // APB write data
    output logic                  pready,    // APB ready
    output logic                  pslverr,   // APB error
    output logic [31:0]           prdata,    // APB read data
    input  wire logic [NPADS-1:0] core_out,  // User logic output values
    input  wire logic [NPADS-1:0] core_oe,   // User logic enables
    output logic      [NPADS-1:0] core_in,   // Pad levels to user logic
    input  wire logic [NPADS-1:0] pad_i,     // Pad input levels
    output logic      [NPADS-1:0] pad_o,     // Pad output values
    output logic      [NPADS-1:0] pad_oe,    // Pad enables, high drives
    output logic                  prog_active // Pads held by cells
);

    localparam int IW = (NPADS > 1) ? $clog2(NPADS) : 1; // Pad index width
    // Select register is one bit wider so a stray index reads as zero
    localparam int SW = IW + 1;                           // Select register width

    // Elaboration check
    // Index, select and read widths serve at most 256 pads
    if (NPADS < 1 || NPADS > 256) begin : g_bad_npads
        $error("NPADS must be 1 to 256");
    end

    pshd_state_t    st_q, st_d;       // Programming phase
    logic           prog_req_q;       // Software mode request
    logic [SW-1:0]  sel_q;            // Selected pad index, one spare bit
    logic [31:0]    rdata_q;          // Registered read data
    logic           err_q;            // Registered slave error
    logic [NPADS-1:0] pin_s1_q;       // Pad sync stage 1
    logic [NPADS-1:0] pin_s2_q;       // Pad sync stage 2
    logic [3:0]     cells [NPADS];    // Cell words of each pad

    // Address decode on the whole byte address; unaligned offsets hit nothing
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire hit_ctrl = (paddr == PSHD_CTRL_OFS);
    wire hit_stat = (paddr == PSHD_STAT_OFS);
    wire hit_pre  = (paddr == PSHD_PRESET_OFS);
    wire hit_sel  = (paddr == PSHD_SEL_OFS);
    wire hit_cell = (paddr == PSHD_CELL_OFS);
    wire hit_any  = hit_ctrl | hit_stat | hit_pre | hit_sel | hit_cell;
    wire in_prog  = (st_q != PSHD_ST_NORMAL);

    // Cells may only change outside programming so entry sees a stable set
    wire wr_cell  = wr & hit_cell & ~in_prog;
    wire wr_pre   = wr & hit_pre & ~in_prog;

    // Control and select writes are taken in any phase so the request can drop
    wire wr_ctrl  = wr & hit_ctrl;              // Mode request write
    wire wr_sel   = wr & hit_sel;               // Pad index write

    // Preset word, input cell pattern supplied on the controller's behalf
    wire [1:0] pre_code = pwdata[PSHD_PRE_CODE_MSB:PSHD_PRE_CODE_LSB];
    logic [3:0] pre_word;
    always_comb begin
        pre_word = '0;                               // Cells not named below stay 0
        case (pre_code)
            PSHD_PRE_LOW: begin
                pre_word[PSHD_CELL_IN_BIT] = 1'b1;   // Input cell 1
                pre_word[PSHD_CELL_OE_BIT] = 1'b1;   // Driving, output cell 0
            end
            PSHD_PRE_HIGH: begin
                pre_word[PSHD_CELL_OE_BIT]  = 1'b1;  // Driving
                pre_word[PSHD_CELL_OUT_BIT] = 1'b1;  // High level, input cell 0
            end
            PSHD_PRE_LAST: begin
                pre_word[PSHD_CELL_LK_BIT] = 1'b1;   // Snapshot replaces all three
            end
            default: begin                           // Tri-state
                pre_word[PSHD_CELL_IN_BIT] = 1'b1;   // Input cell 1, oe and out 0
            end
        endcase
    end

    // Phase machine: capture one cycle, then hold until the request drops
    // Dropping the request during capture abandons entry before any pad moves
    always_comb begin
        case (st_q)
            PSHD_ST_NORMAL: st_d = prog_req_q ? PSHD_ST_CAPT : PSHD_ST_NORMAL;
            PSHD_ST_CAPT:   st_d = prog_req_q ? PSHD_ST_HOLD : PSHD_ST_NORMAL;
            PSHD_ST_HOLD:   st_d = prog_req_q ? PSHD_ST_HOLD : PSHD_ST_NORMAL;
            default:        st_d = PSHD_ST_NORMAL;
        endcase
    end

    // Phase register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= PSHD_ST_NORMAL;
        end else begin
            st_q <= st_d;
        end
    end

    // Pad synchroniser, two stages before any use
    // Only the second stage is read; the first may still be metastable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pad_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Programming mode request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_req_q <= 1'b0;
        end else if (wr_ctrl) begin
            prog_req_q <= pwdata[PSHD_CTRL_PROG_BIT];   // Request bit
        end
    end

    // Pad index select; the spare bit marks an index past the last pad
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= '0;
        end else if (wr_sel) begin
            sel_q <= pwdata[SW-1:0];
        end
    end

    // Cell word of the selected pad, zero past the last pad
    wire [3:0] sel_cells = (int'(sel_q) < NPADS) ? cells[sel_q[IW-1:0]] : 4'h0;

    // Read mux, registered for the access cycle; write cycles capture zero
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_d[PSHD_CTRL_PROG_BIT] = prog_req_q;
        end else if (hit_stat) begin
            rd_d[$bits(pshd_state_t)-1:0] = st_q;
        end else if (hit_sel) begin
            rd_d[SW-1:0] = sel_q;
        end else if (hit_cell) begin
            rd_d[PSHD_CELL_LK_BIT:PSHD_CELL_IN_BIT] = sel_cells;
        end
    end

    // Zero-wait APB: answer in the first access cycle
    // Data and error are decided at setup so both stand through the access phase
    // Limitation: an address change between setup and access is not tracked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (psel && !penable) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            err_q   <= ~hit_any;
        end
    end

    // Per-pad controls; only the load strobe differs between pads
    wire       cap_now   = (st_q == PSHD_ST_CAPT);            // Snapshot cycle
    wire       hold_now  = (st_q == PSHD_ST_HOLD);            // Cells own the pads
    wire [3:0] load_word = wr_pre ? pre_word : pwdata[3:0];   // Preset or custom word

    // Handshake outputs are combinational; data outputs come from flip-flops
    // prog_active rises two edges after the request write, with the hold phase
    assign pready      = 1'b1;
    assign pslverr     = acc & err_q;
    assign prdata      = rdata_q;
    assign prog_active = hold_now;

    // Pad instances, one per pad; each owns its cells, the parent only decodes
    for (genvar i = 0; i < NPADS; i++) begin : g_pad
        wire sel_me = (int'(sel_q) == i);                  // This pad is selected
        wire ld_me  = (wr_cell && sel_me) || wr_pre;       // Custom or preset load
        pshd_pad_cell u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .load     (ld_me),
            .load_val (load_word),
            .capture  (cap_now),
            .hold     (hold_now),
            .core_out (core_out[i]),
            .core_oe  (core_oe[i]),
            .pad_in   (pin_s2_q[i]),
            .pad_out  (pad_o[i]),
            .pad_oe   (pad_oe[i]),
            .core_in  (core_in[i]),
            .cells    (cells[i])
        );
    end

endmodule

// ===== hw/pshd_pkg.sv
/*
 * Package for the programming pad state hold block: register map, field
 * layout, preset encodings and reset values.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package pshd_pkg;

    // Register byte offsets
    localparam logic [11:0] PSHD_CTRL_OFS   = 12'h000; // Mode control
    localparam logic [11:0] PSHD_STAT_OFS   = 12'h004; // Status
    localparam logic [11:0] PSHD_PRESET_OFS = 12'h008; // Preset loader
    localparam logic [11:0] PSHD_SEL_OFS    = 12'h00C; // Pad index select
    localparam logic [11:0] PSHD_CELL_OFS   = 12'h010; // Cells of selected pad

    // Control fields
    localparam int PSHD_CTRL_PROG_BIT = 0; // Programming mode request

    // Cell word fields, one pad
    localparam int PSHD_CELL_IN_BIT  = 0; // Input cell
    localparam int PSHD_CELL_OE_BIT  = 1; // Output enable cell
    localparam int PSHD_CELL_OUT_BIT = 2; // Output cell
    localparam int PSHD_CELL_LK_BIT  = 3; // Hold-last-state flag

    // Preset loader fields
    localparam int PSHD_PRE_CODE_LSB = 0; // Preset code, 2 bits
    localparam int PSHD_PRE_CODE_MSB = 1;

    // Output state presets
    typedef enum logic [1:0] {
        PSHD_PRE_Z    = 2'h0,  // Tri-state
        PSHD_PRE_LOW  = 2'h1,  // Drive low
        PSHD_PRE_HIGH = 2'h2,  // Drive high
        PSHD_PRE_LAST = 2'h3   // Hold last driven value
    } pshd_preset_t;

    // Cell reset value: tri-state preset pattern (in=1, oe=0, out=0)
    localparam logic [3:0] PSHD_CELL_RST = 4'h1;

    // Programming phase states, one-hot
    typedef enum logic [2:0] {
        PSHD_ST_NORMAL = 3'h1,  // Pads follow user logic
        PSHD_ST_CAPT   = 3'h2,  // One cycle: snapshot last driven values
        PSHD_ST_HOLD   = 3'h4   // Pads fixed by cells
    } pshd_state_t;

endpackage

// ===== hw/pshd_pad_cell.sv
/*
 * One pad's three scan cells and the pad-side multiplexer.
 * Assumes the parent provides load strobes and mode controls on pclk.
 */
`timescale 1ns/1ps
module pshd_pad_cell
    import pshd_pkg::*;
(
    input  wire logic       pclk,       // Clock
    input  wire logic       presetn,    // Async reset, active low
    input  wire logic       load,       // Write cell word
    input  wire logic [3:0] load_val,   // Cell word to write
    input  wire logic       capture,    // Snapshot cycle at entry
    input  wire logic       hold,       // Programming in force
    input  wire logic       core_out,   // User logic output value
    input  wire logic       core_oe,    // User logic output enable
    input  wire logic       pad_in,     // Synchronised pad level
    output logic            pad_out,    // Pad output value
    output logic            pad_oe,     // Pad output enable, high drives
    output logic            core_in,    // Pad level to user logic
    output logic [3:0]      cells       // Stored cell word
);

    logic [3:0] cell_q;   // {last, out, oe, in}
    logic [2:0] last_q;   // Snapshot {out, oe, in}
    logic       pout_q;   // Registered pad value
    logic       poe_q;    // Registered pad enable

    // Effective cells: snapshot replaces all three for hold-last
    wire        use_last = cell_q[PSHD_CELL_LK_BIT];
    wire        eff_oe   = use_last ? last_q[1] : cell_q[PSHD_CELL_OE_BIT];
    wire        eff_out  = use_last ? last_q[2] : cell_q[PSHD_CELL_OUT_BIT];
    // Only oe and out reach the pad; input cell never steers it
    wire        hold_oe  = eff_oe;
    wire        hold_out = eff_oe & eff_out;

    // Cell storage, all cells and the last flag loaded together as one word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_q <= PSHD_CELL_RST;
        end else if (load) begin
            cell_q <= load_val;
        end
    end

    // Snapshot the value being driven just before entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 3'h0;
        end else if (capture) begin
            last_q <= {core_out, core_oe, pad_in};
        end
    end

    // Pad drive registered; normal function outside programming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pout_q <= 1'b0;
            poe_q  <= 1'b0;
        end else if (hold) begin
            pout_q <= hold_out;
            poe_q  <= hold_oe;
        end else begin
            pout_q <= core_out;
            poe_q  <= core_oe;
        end
    end

    assign pad_out = pout_q;
    assign pad_oe  = poe_q;
    // Input cell value is presented to the core while held
    assign core_in = hold ? (use_last ? last_q[0] : cell_q[PSHD_CELL_IN_BIT]) : pad_in;
    assign cells   = cell_q;

endmodule

// ===== bench/pshd_checker.sv
/* Checker for pshd_top: pad hold timing, pad release and APB answers.
   Assumes a bind onto pshd_top with the same NPADS. */
`timescale 1ns/1ps
module pshd_checker
    import pshd_pkg::*;
#(
    parameter int NPADS = 16
)(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [NPADS-1:0] core_out,
    input wire logic [NPADS-1:0] core_oe,
    input wire logic [NPADS-1:0] core_in,
    input wire logic [NPADS-1:0] pad_i,
    input wire logic [NPADS-1:0] pad_o,
    input wire logic [NPADS-1:0] pad_oe,
    input wire logic             prog_active
);
    logic [2:0] held_q; // Cycles in hold, saturating; skips the entry settling
    wire ctl_wr = psel && penable && pwrite && (paddr == PSHD_CTRL_OFS);
    wire mapped = paddr inside {PSHD_CTRL_OFS, PSHD_STAT_OFS, PSHD_PRESET_OFS,
                                PSHD_SEL_OFS, PSHD_CELL_OFS};
    // Hold counter, cleared on leaving hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) held_q <= 3'h0;
        else if (!prog_active) held_q <= 3'h0;
        else if (held_q != 3'h7) held_q <= held_q + 3'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_tri_quiet: assert property (prog_active && held_q >= 3'h3 |-> (pad_o & ~pad_oe) == '0)
        else $error("driven value on a tri-stated pad");
    a_hold_still: assert property (prog_active && held_q >= 3'h3 |->
        $stable(pad_o) && $stable(pad_oe) && $stable(core_in))
        else $error("pad moved while held");
    a_enter_fast: assert property (ctl_wr && pwdata[0] && !prog_active |-> ##[2:3] prog_active)
        else $error("hold not entered");
    a_exit_fast: assert property (ctl_wr && !pwdata[0] && prog_active |-> ##[1:2] !prog_active)
        else $error("hold not left");
    a_pads_follow: assert property (!prog_active && $past(!prog_active) && $past(presetn) |->
        pad_o == $past(core_out) && pad_oe == $past(core_oe))
        else $error("pads not following user logic");
    a_sync_in: assert property (!prog_active && $past(presetn) && $past(presetn, 2) |->
        core_in == $past(pad_i, 2))
        else $error("pad level not passed to user logic");
    a_ready_now: assert property (psel && !penable |=> pready)
        else $error("access not answered at once");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not flagged");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access flagged");
endmodule
bind pshd_top pshd_checker #(.NPADS(NPADS)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .prog_active(prog_active));

// ===== bench/pshd_ctl_model.sv
/* Programming controller model: loads pad cells over APB, then enters hold.
   Assumes a zero-wait slave, but waits for pready whatever it does. */
`timescale 1ns/1ps
module pshd_ctl_model
    import pshd_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   pready,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // One transfer; request held until pready seen high at an edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cells are loaded before this is called; input cell set by preset code
    task enter;
        xfer(1'b1, PSHD_CTRL_OFS, 32'h1);
        repeat (6) @(posedge pclk);
    endtask
    // Release back to user logic
    task leave;
        xfer(1'b1, PSHD_CTRL_OFS, 32'h0);
        repeat (3) @(posedge pclk);
    endtask
endmodule

// ===== bench/test_pshd_top.sv
/* Testbench for pshd_top: presets, snapshot hold, custom cells, refusals.
   Assumes the controller model drives APB; read results go through a queue. */
`timescale 1ns/1ps
module test_pshd_top;
    import pshd_pkg::*;
    localparam int NP = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NP-1:0] core_out, core_oe, pad_i, core_in, pad_o, pad_oe, lo, le, li;
    logic [32:0] expq[$]; // Expected {pslverr, prdata} per read
    int mismatches, checks;
    pshd_ctl_model ctl (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    pshd_top #(.NPADS(NP)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .prog_active(prog_active));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task rdx(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        ctl.xfer(1'b0, a, 32'h0);
    endtask
    task pads(input logic [NP-1:0] oe, input logic [NP-1:0] o, input logic [NP-1:0] ci);
        @(posedge pclk);
        #1 chk({21'h0, pad_oe, pad_o, core_in}, {21'h0, oe, o, ci});
    endtask
    // Read monitor: oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) chk(33'h0, 33'h1);
            else chk({pslverr, prdata}, expq.pop_front());
        end
    end
    // Watchdog against a hung bus
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up;
    end
    initial begin
        logic [3:0] cw;
        logic [15:0] cv;
        presetn = 1'b0;
        core_out = '0;
        core_oe = '0;
        pad_i = '0;
        mismatches = 0;
        checks = 0;
        cv = 16'h4527; // Pads 0..3: all ones, low, tri with don't-cares, tri
        void'($urandom(32'h538ad90c));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        pads('0, '0, '0);
        rdx(PSHD_STAT_OFS, 33'h1);
        rdx(PSHD_CELL_OFS, 33'h1);
        rdx(12'h014, {1'b1, 32'h0});
        $display("reset test done");
        for (int c = 0; c < 3; c++) begin
            cw = (c == 0) ? 4'h1 : (c == 1) ? 4'h3 : 4'h6;
            ctl.xfer(1'b1, PSHD_PRESET_OFS, c);
            ctl.xfer(1'b1, PSHD_SEL_OFS, 32'($urandom_range(NP - 1)));
            rdx(PSHD_CELL_OFS, {29'h0, cw});
            core_out <= 4'($urandom);
            core_oe <= 4'($urandom);
            ctl.enter;
            pads({NP{cw[1]}}, {NP{cw[1] & cw[2]}}, {NP{cw[0]}});
            rdx(PSHD_STAT_OFS, 33'h4);
            rdx(PSHD_CTRL_OFS, 33'h1);
            ctl.leave;
            pads(core_oe, core_out, pad_i);
        end
        $display("preset test done");
        lo = 4'($urandom);
        le = 4'($urandom);
        li = 4'($urandom);
        @(posedge pclk);
        core_out <= lo;
        core_oe <= le;
        pad_i <= li;
        ctl.xfer(1'b1, PSHD_PRESET_OFS, 32'h3);
        ctl.enter;
        core_out <= ~lo;
        pad_i <= ~li;
        repeat (3) @(posedge pclk);
        pads(le, le & lo, li);
        ctl.leave;
        $display("last state test done");
        for (int i = 0; i < NP; i++) begin
            ctl.xfer(1'b1, PSHD_SEL_OFS, i);
            ctl.xfer(1'b1, PSHD_CELL_OFS, {28'h0, cv[4*i +: 4]});
        end
        rdx(PSHD_CELL_OFS, 33'h4);
        ctl.enter;
        pads(4'b0011, 4'b0001, 4'b0101);
        ctl.xfer(1'b1, PSHD_CELL_OFS, 32'h0);
        rdx(PSHD_CELL_OFS, 33'h4);
        pads(4'b0011, 4'b0001, 4'b0101);
        ctl.leave;
        ctl.xfer(1'b1, PSHD_SEL_OFS, 32'h7);
        rdx(PSHD_SEL_OFS, 33'h7);
        rdx(PSHD_CELL_OFS, 33'h0);
        $display("custom cell test done");
        repeat (2) @(posedge pclk);
        if (expq.size() != 0) chk(33'h0, 33'h1);
        wrap_up;
    end
endmodule
